// ### inc/kmss_pkg.sv
// Constants, register map and helpers of the key matrix scanner
package kmss_pkg;

  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  localparam int NUM_SCAN       = 6;
  localparam int NUM_SENSE      = 5;
  localparam int NUM_KEYS       = 30;
  localparam int SEG_BITS       = 75;
  localparam int NUM_PORTS      = 4;
  localparam int CTRL_W         = 8;
  localparam int SEG2_W         = 11;
  localparam int TCNT_W         = 10;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SEG0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SEG1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SEG2 = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_KEYS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h14;

  localparam int CTRL_SLEEP_LO  = 0;
  localparam int CTRL_SLEEP_HI  = 1;
  localparam int CTRL_SEGSEL_A  = 2;
  localparam int CTRL_SEGSEL_B  = 3;
  localparam int CTRL_PORT_LSB  = 4;
  localparam int CTRL_PORT_W    = 3;
  localparam int CTRL_SEG_OFF   = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  localparam int KEYS_ACK_BIT   = 30;
  localparam int STAT_REQ       = 0;
  localparam int STAT_SYS_RST   = 1;
  localparam int STAT_SLEEP     = 2;
  localparam int STAT_SCANNING  = 3;

  // Oscillator periods per scan, per scan line, and to the read request
  localparam int SCAN_T         = 288;
  localparam int LINE_T         = SCAN_T / NUM_SCAN;
  localparam int REQ_T          = 615;
  // Period of the internal oscillator and its divider at sys_clk
  localparam int SYS_PERIOD_NS  = 8;
  localparam int OSC_PERIOD_NS  = 64;
  localparam int OSC_DIV        = OSC_PERIOD_NS / SYS_PERIOD_NS;
  localparam int OSC_CNT_W      = 8;

  typedef enum logic [1:0] {
    KMSS_IDLE,
    KMSS_SCAN,
    KMSS_WAIT,
    KMSS_REQ
  } kmss_state_e;

  // Offset of an oscillator count within the current scan
  function automatic logic [TCNT_W-1:0] kmss_in_scan(
    input logic [TCNT_W-1:0] t
  );
    kmss_in_scan = (t >= TCNT_W'(SCAN_T)) ? t - TCNT_W'(SCAN_T) : t;
  endfunction : kmss_in_scan

  // Scan line driven at a given count
  function automatic logic [2:0] kmss_line_of(input logic [TCNT_W-1:0] t);
    kmss_line_of = 3'(kmss_in_scan(t) / TCNT_W'(LINE_T));
  endfunction : kmss_line_of

  // Last oscillator period of a scan line slot
  function automatic logic kmss_slot_last(input logic [TCNT_W-1:0] t);
    kmss_slot_last = (kmss_in_scan(t) % TCNT_W'(LINE_T))
                     == TCNT_W'(LINE_T - 1);
  endfunction : kmss_slot_last

endpackage : kmss_pkg

// ### logic/kmss_osc.sv
// Internal oscillator model: one-cycle tick per oscillator period
`timescale 1ns/1ps
module kmss_osc
  import kmss_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      tick
);
  logic [OSC_CNT_W-1:0] cnt_q;
  logic                 tick_q;
  wire                  wrap = cnt_q == OSC_CNT_W'(OSC_DIV - 1);

  // A stopped oscillator restarts a full period after it is released
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= (!run || wrap) ? '0 : cnt_q + 1'b1;
      tick_q <= run && wrap;
    end
  end

  assign tick = tick_q;
endmodule : kmss_osc

// ### logic/kmss_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module kmss_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : kmss_sync

// ### logic/kmss_top.sv
// Key matrix scanner with sleep and system-reset control
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps

module kmss_top (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic [kmss_pkg::ADDR_W-1:0]   addr,
  input  wire logic [kmss_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [kmss_pkg::DATA_W-1:0]   rdata,
  input  wire logic [kmss_pkg::NUM_SENSE-1:0] sense_line_in,
  input  wire logic                          transfer_select_in,
  input  wire logic                          supply_low_reset,
  output logic      [kmss_pkg::NUM_SCAN-1:0] scan_line_out,
  output logic                               data_out_o,
  output logic                               data_out_oe,
  output logic      [kmss_pkg::SEG_BITS-1:0] seg_data_out,
  output logic      [kmss_pkg::NUM_PORTS-1:0] port_out,
  output logic      [kmss_pkg::NUM_PORTS-1:0] port_mode,
  output logic                               display_on,
  output logic                               osc_running
);
  import kmss_pkg::*;

  // Pin inputs after synchronisation
  logic [NUM_SENSE-1:0]  sense_s;
  logic                  ts_s;
  logic                  supply_s;
  logic                  ts_prev_q;

  // Software-visible state
  logic [CTRL_W-1:0]     ctrl_q;
  logic [DATA_W-1:0]     seg0_q;
  logic [DATA_W-1:0]     seg1_q;
  logic [SEG2_W-1:0]     seg2_q;
  logic [3:0]            recv_q;
  logic                  sys_rst_q;
  logic [DATA_W-1:0]     rdata_q;

  // Scan engine
  kmss_state_e           state_q;
  kmss_state_e           state_d;
  logic [TCNT_W-1:0]     t_q;
  logic [TCNT_W-1:0]     t_d;
  logic [NUM_KEYS-1:0]   cur_q;
  logic [NUM_KEYS-1:0]   cur_d;
  logic [NUM_KEYS-1:0]   first_q;
  logic [NUM_KEYS-1:0]   first_d;
  logic [NUM_KEYS-1:0]   keys_q;
  logic [NUM_KEYS-1:0]   keys_d;
  logic                  ack_q;
  logic                  ack_d;
  logic                  req_q;
  logic                  req_d;
  logic [NUM_KEYS-1:0]   fill;
  logic                  osc_tick;

  // Registered pin outputs
  logic [NUM_SCAN-1:0]   scan_q;
  logic                  dout_q;
  logic                  dout_oe_q;
  logic [SEG_BITS-1:0]   seg_out_q;
  logic [NUM_PORTS-1:0]  port_out_q;
  logic [NUM_PORTS-1:0]  port_mode_q;
  logic                  disp_q;
  logic                  osc_run_q;

  kmss_sync #(.W(NUM_SENSE)) u_sync_sense (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       (sense_line_in),
    .q       (sense_s)
  );

  kmss_sync #(.W(2)) u_sync_ctl (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       ({transfer_select_in, supply_low_reset}),
    .q       ({ts_s, supply_s})
  );

  // Oscillator stops in sleep unless a press has started a scan
  wire sleep_w    = ctrl_q[CTRL_SLEEP_LO] | ctrl_q[CTRL_SLEEP_HI];
  wire osc_run_w  = !sys_rst_q
                    && (!sleep_w || state_q != KMSS_IDLE);

  kmss_osc u_osc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .run     (osc_run_q),
    .tick    (osc_tick)
  );

  // Bus decode
  wire wr_ctrl    = wr_stb && addr == ADDR_CTRL;
  wire wr_seg0    = wr_stb && addr == ADDR_SEG0;
  wire wr_seg1    = wr_stb && addr == ADDR_SEG1;
  wire wr_seg2    = wr_stb && addr == ADDR_SEG2;
  // Only a read during a pending request counts; earlier data is invalid
  wire key_read   = rd_stb && addr == ADDR_KEYS
                    && state_q == KMSS_REQ;
  wire ts_fall    = ts_prev_q && !ts_s;
  wire all_recv   = &recv_q;

  // Lines given to segment outputs never scan
  wire seg_a      = ctrl_q[CTRL_SEGSEL_A];
  wire seg_b      = ctrl_q[CTRL_SEGSEL_B];
  wire [NUM_SCAN-1:0] line_en =
    {4'hf, !seg_a, !(seg_a || seg_b)};

  // Standby level of each scan line for the current mode
  wire [1:0] sleep_code =
    {ctrl_q[CTRL_SLEEP_LO], ctrl_q[CTRL_SLEEP_HI]};
  wire [NUM_SCAN-1:0] sleep_pat =
    (sleep_code == 2'h1) ? 6'h20 :
    (sleep_code == 2'h2) ? 6'h30 : 6'h3f;
  wire [NUM_SCAN-1:0] idle_pat =
    (sleep_w ? sleep_pat : 6'h3f) & line_en;

  // Active scan pulse, withheld from lines that sleep holds low
  wire [2:0]          line_idx = kmss_line_of(t_q);
  wire [NUM_SCAN-1:0] line_hot = NUM_SCAN'(1) << line_idx;
  wire [NUM_SCAN-1:0] scan_pat = line_hot & idle_pat;

  // Sense sampled at the end of each line slot
  wire sample     = state_q == KMSS_SCAN && osc_tick
                    && kmss_slot_last(t_q);
  wire end_scan1  = sample && t_q == TCNT_W'(SCAN_T - 1);
  wire end_scan2  = sample && t_q == TCNT_W'(2 * SCAN_T - 1);
  // The first period after a press is partial, so count one more tick
  wire at_req     = t_q == TCNT_W'(REQ_T);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SCAN; gi++) begin : g_fill
      wire hit = sample && line_idx == 3'(gi) && scan_pat[gi];
      // Each sense input lands at its own key position
      assign fill[gi*NUM_SENSE +: NUM_SENSE] =
        cur_q[gi*NUM_SENSE +: NUM_SENSE]
        | (hit ? sense_s : NUM_SENSE'(0));
    end
  endgenerate

  // Scan sequencing
  always_comb begin
    state_d = state_q;
    t_d     = t_q;
    cur_d   = cur_q;
    first_d = first_q;
    keys_d  = keys_q;
    ack_d   = ack_q;
    req_d   = req_q;
    if (sys_rst_q) begin
      state_d = KMSS_IDLE;
      t_d     = '0;
      cur_d   = '0;
      first_d = '0;
      keys_d  = '0;
      ack_d   = 1'b0;
      req_d   = 1'b0;
    end else begin
      unique case (state_q)
        KMSS_IDLE: begin
          if (|sense_s) begin
            state_d = KMSS_SCAN;
            t_d     = '0;
            cur_d   = '0;
          end
        end
        KMSS_SCAN: begin
          if (osc_tick) begin
            t_d   = t_q + 1'b1;
            cur_d = fill;
            if (end_scan1) begin
              first_d = fill;
              cur_d   = '0;
            end else if (end_scan2) begin
              cur_d = '0;
              if (fill == first_q && |fill) begin
                state_d = KMSS_WAIT;
              end else if (|fill) begin
                t_d = '0;
              end else begin
                state_d = KMSS_IDLE;
              end
            end
          end
        end
        KMSS_WAIT: begin
          if (osc_tick) begin
            t_d = t_q + 1'b1;
            if (at_req) begin
              keys_d  = first_q;
              ack_d   = sleep_w;
              req_d   = 1'b1;
              state_d = KMSS_REQ;
            end
          end
        end
        KMSS_REQ: begin
          // Key bits and acknowledge are frozen until the read
          if (key_read) begin
            req_d   = 1'b0;
            state_d = KMSS_SCAN;
            t_d     = '0;
            cur_d   = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= KMSS_IDLE;
      t_q     <= '0;
      cur_q   <= '0;
      first_q <= '0;
    end else begin
      state_q <= state_d;
      t_q     <= t_d;
      cur_q   <= cur_d;
      first_q <= first_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      keys_q <= '0;
      ack_q  <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      keys_q <= keys_d;
      ack_q  <= ack_d;
      req_q  <= req_d;
    end
  end

  // Control and display bits survive system reset so data can be loaded
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg0_q <= '0;
      seg1_q <= '0;
      seg2_q <= '0;
    end else begin
      if (wr_seg0) seg0_q <= wdata;
      if (wr_seg1) seg1_q <= wdata;
      if (wr_seg2) seg2_q <= wdata[SEG2_W-1:0];
    end
  end

  // System reset from the supply detector
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_rst_q <= 1'b1;
      recv_q    <= '0;
      ts_prev_q <= 1'b0;
    end else begin
      ts_prev_q <= ts_s;
      if (supply_s) begin
        sys_rst_q <= 1'b1;
        recv_q    <= '0;
      end else begin
        recv_q <= recv_q | {wr_seg2, wr_seg1, wr_seg0, wr_ctrl};
        if (ts_fall && all_recv) sys_rst_q <= 1'b0;
      end
    end
  end

  // Read data, valid in the cycle after the strobe
  wire [DATA_W-1:0] keys_word =
    DATA_W'({ack_q, keys_q});
  wire [DATA_W-1:0] stat_word =
    DATA_W'({state_q != KMSS_IDLE, sleep_w, sys_rst_q, req_q});
  wire [DATA_W-1:0] rd_mux =
    (addr == ADDR_CTRL) ? DATA_W'(ctrl_q) :
    (addr == ADDR_SEG0) ? seg0_q :
    (addr == ADDR_SEG1) ? seg1_q :
    (addr == ADDR_SEG2) ? DATA_W'(seg2_q) :
    (addr == ADDR_KEYS) ? keys_word :
    (addr == ADDR_STAT) ? stat_word : '0;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_stb ? rd_mux : '0;
    end
  end

  // Display and general-purpose ports
  wire [SEG_BITS-1:0] seg_all =
    {seg2_q, seg1_q, seg0_q};
  wire [CTRL_PORT_W-1:0] port_cnt =
    ctrl_q[CTRL_PORT_LSB +: CTRL_PORT_W];
  wire disp_d = !sys_rst_q && !sleep_w
                && !ctrl_q[CTRL_SEG_OFF];
  wire [NUM_PORTS-1:0] pmode_d;
  wire [NUM_PORTS-1:0] pout_d;

  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      // Reset forces these pins back to low segment outputs
      assign pmode_d[gi] = !sys_rst_q
                           && port_cnt > CTRL_PORT_W'(gi);
      assign pout_d[gi]  = pmode_d[gi] && seg_all[gi*3];
    end
  endgenerate

  // Open-drain request: drive low only outside a transfer
  wire dout_oe_d = req_q && !ts_s && !sys_rst_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_q    <= '0;
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
      osc_run_q <= 1'b0;
    end else begin
      scan_q    <= (state_q == KMSS_SCAN) ? scan_pat : idle_pat;
      dout_q    <= 1'b0;
      dout_oe_q <= dout_oe_d;
      osc_run_q <= osc_run_w;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_out_q   <= '0;
      port_out_q  <= '0;
      port_mode_q <= '0;
      disp_q      <= 1'b0;
    end else begin
      seg_out_q   <= disp_d ? seg_all : '0;
      port_out_q  <= pout_d;
      port_mode_q <= pmode_d;
      disp_q      <= disp_d;
    end
  end

  assign rdata         = rdata_q;
  assign scan_line_out = scan_q;
  assign data_out_o    = dout_q;
  assign data_out_oe   = dout_oe_q;
  assign seg_data_out  = seg_out_q;
  assign port_out      = port_out_q;
  assign port_mode     = port_mode_q;
  assign display_on    = disp_q;
  assign osc_running   = osc_run_q;

endmodule : kmss_top

// ### test/kmss_keypad.sv
// Key matrix model: a closed key joins its scan line to its sense line
`timescale 1ns/1ps
module kmss_keypad (
  input  wire logic [kmss_pkg::NUM_SCAN-1:0]  scan_line_out,
  input  wire logic [kmss_pkg::NUM_KEYS-1:0]  pressed,
  output logic      [kmss_pkg::NUM_SENSE-1:0] sense_line_in
);
  import kmss_pkg::*;
  // Ideal diode per key, so several keys never sneak into each other
  always_comb begin
    sense_line_in = '0;
    for (int i = 0; i < NUM_SCAN; i++) begin
      for (int j = 0; j < NUM_SENSE; j++) begin
        if (scan_line_out[i] && pressed[i*NUM_SENSE+j]) begin
          sense_line_in[j] = 1'b1;
        end
      end
    end
  end
endmodule : kmss_keypad

// ### test/kmss_monitor.sv
// Port checker for the key matrix scanner
`timescale 1ns/1ps
module kmss_monitor (
  input wire logic                           sys_clk,
  input wire logic                           reset_n,
  input wire logic [kmss_pkg::ADDR_W-1:0]    addr,
  input wire logic                           rd_stb,
  input wire logic [kmss_pkg::DATA_W-1:0]    rdata,
  input wire logic                           transfer_select_in,
  input wire logic                           supply_low_reset,
  input wire logic [kmss_pkg::NUM_SCAN-1:0]  scan_line_out,
  input wire logic                           data_out_oe,
  input wire logic [kmss_pkg::SEG_BITS-1:0]  seg_data_out,
  input wire logic [kmss_pkg::NUM_PORTS-1:0] port_mode,
  input wire logic                           display_on,
  input wire logic                           osc_running
);
  import kmss_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_quiet: assert property
    (!$past(rd_stb) |-> rdata == '0)
    else $error("read data seen outside a read answer");
  a_select_frees_oe: assert property
    (transfer_select_in [*6] |-> !data_out_oe)
    else $error("request still driven under transfer select");
  a_blank_display: assert property
    (!display_on [*2] |-> seg_data_out == '0)
    else $error("segments driven while display is off");
  a_supply_reset: assert property
    (supply_low_reset [*6] |-> !display_on && port_mode == '0 && !data_out_oe)
    else $error("supply reset did not take hold");
  a_osc_stops: assert property
    ($rose(supply_low_reset) |-> ##[1:6] !osc_running)
    else $error("oscillator kept running in supply reset");
  // Idle levels (normal, segment lines, sleep 6'h30) are not scan pulses
  a_scan_onehot: assert property
    (osc_running
     && !(scan_line_out inside {6'h3f, 6'h3e, 6'h3c, 6'h30})
     |-> $onehot0(scan_line_out))
    else $error("more than one scan line pulsed");
  a_req_holds: assert property
    ((data_out_oe && !transfer_select_in && !rd_stb && !supply_low_reset)
     [*4] |=> data_out_oe)
    else $error("request dropped without a read");
  a_read_clears: assert property
    (rd_stb && addr == ADDR_KEYS && data_out_oe |-> ##[1:4] !data_out_oe)
    else $error("key read did not clear the request");
endmodule : kmss_monitor

bind kmss_top kmss_monitor u_kmss_monitor (.sys_clk(sys_clk),
  .reset_n(reset_n), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
  .transfer_select_in(transfer_select_in),
  .supply_low_reset(supply_low_reset), .scan_line_out(scan_line_out),
  .data_out_oe(data_out_oe), .seg_data_out(seg_data_out),
  .port_mode(port_mode), .display_on(display_on),
  .osc_running(osc_running));

// ### test/testbench.sv
// Self-checking bench for the key matrix scanner
`timescale 1ns/1ps
module testbench;
  import kmss_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic [ADDR_W-1:0]    addr = '0;
  logic [DATA_W-1:0]    wdata = '0;
  logic [DATA_W-1:0]    rdata;
  logic [DATA_W-1:0]    rv;
  logic                 wr_stb = 1'b0;
  logic                 rd_stb = 1'b0;
  logic                 tsel = 1'b0;
  logic                 supply = 1'b0;
  logic [NUM_KEYS-1:0]  keys = '0;
  logic [NUM_SENSE-1:0] sense;
  logic [NUM_SCAN-1:0]  scan;
  logic [NUM_PORTS-1:0] pout;
  logic [NUM_PORTS-1:0] pmode;
  logic                 oe;
  logic                 disp;
  logic                 osc;
  logic                 dout;
  logic [SEG_BITS-1:0]  seg;
  logic [5:0]           pat [1:3] = '{6'h30, 6'h20, 6'h3f};
  int                   n_fail = 0;
  int                   num_checks = 0;
  int                   cyc = 0;
  int                   n;

  always #4 sys_clk = ~sys_clk;

  kmss_top u_kmss_top (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .sense_line_in(sense), .transfer_select_in(tsel),
    .supply_low_reset(supply), .scan_line_out(scan), .data_out_o(dout),
    .data_out_oe(oe), .seg_data_out(seg), .port_out(pout),
    .port_mode(pmode), .display_on(disp), .osc_running(osc));
  kmss_keypad u_kmss_keypad (.scan_line_out(scan), .pressed(keys),
    .sense_line_in(sense));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stand one cycle; taken at the edge that ends that cycle
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(posedge sys_clk);
    rv = rdata;
    chk(what, e, rv & m);
  endtask : rchk

  task automatic wait_oe(output int c);
    c = 0;
    while (oe !== 1'b1 && c < 8000) begin
      @(posedge sys_clk);
      c++;
    end
    if (oe !== 1'b1) begin
      n_fail++;
      $display("mismatch request expected 1 seen %b", oe);
    end
  endtask : wait_oe

  // System reset lifts only once control and all display words are in
  task automatic boot;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SEG0, 32'h9);
    wr(ADDR_SEG1, 32'h0);
    wr(ADDR_SEG2, 32'h0);
    @(posedge sys_clk);
    tsel <= 1'b1;
    idle(6);
    tsel <= 1'b0;
    idle(6);
  endtask : boot

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    idle(4);
    reset_n <= 1'b1;
    idle(2);
    chk("idle lines", 32'h3f, 32'(scan));
    rchk("stat in reset", ADDR_STAT, '1, 32'h2);
    boot();
    rchk("stat running", ADDR_STAT, '1, 32'h0);
    chk("display on", 32'h1, 32'(disp));
    chk("segments", 32'h9, seg[31:0]);
    keys <= 30'h0080_0080;
    wait_oe(n);
    chk("request time", 32'h1, 32'(n >= 4920 && n <= 4990));
    chk("data value", 32'h0, 32'(dout));
    // A new press while pending must not disturb the held key word
    keys <= 30'h0000_0001;
    tsel <= 1'b1;
    idle(6);
    chk("oe under select", 32'h0, 32'(oe));
    tsel <= 1'b0;
    idle(6);
    chk("oe after select", 32'h1, 32'(oe));
    wr(ADDR_CTRL, 32'h3);
    rchk("mode while pending", ADDR_STAT, 32'h4, 32'h4);
    wr(ADDR_CTRL, 32'h0);
    rchk("two keys", ADDR_KEYS, '1, 32'h0080_0080);
    chk("key count", 32'h1, 32'($countones(rv[29:0]) < 3));
    keys <= '0;
    idle(3);
    chk("oe cleared", 32'h0, 32'(oe));
    keys <= 30'h0000_1000;
    idle(2000);
    keys <= '0;
    idle(7000);
    chk("short press", 32'h0, 32'(oe));
    chk("lines released", 32'h3f, 32'(scan));
    wr(ADDR_CTRL, 32'h4);
    keys <= 30'h0000_1008;
    wait_oe(n);
    rchk("segment lines", ADDR_KEYS, '1, 32'h0000_1000);
    keys <= '0;
    idle(6000);
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_CTRL, 32'(i));
      idle(4);
      chk("sleep idle", 32'(pat[i]), 32'(scan));
    end
    wr(ADDR_CTRL, 32'h42);
    idle(4);
    chk("sleep ports", 32'h3, 32'(pout));
    chk("sleep port mode", 32'hf, 32'(pmode));
    chk("sleep display", 32'h0, 32'(disp));
    chk("sleep osc", 32'h0, 32'(osc));
    keys <= 30'h0800_0000;
    wait_oe(n);
    rchk("sleep key", ADDR_KEYS, '1, 32'h4800_0000);
    rchk("still asleep", ADDR_STAT, 32'h4, 32'h4);
    keys <= '0;
    wr(ADDR_CTRL, 32'h0);
    idle(4);
    chk("wake osc", 32'h1, 32'(osc));
    rchk("awake", ADDR_STAT, 32'h4, 32'h0);
    keys <= 30'h2000_0001;
    wait_oe(n);
    rchk("corner keys", ADDR_KEYS, '1, 32'h2000_0001);
    wait_oe(n);
    supply <= 1'b1;
    keys <= '0;
    idle(8);
    rchk("keys in reset", ADDR_KEYS, '1, 32'h0);
    chk("oe in reset", 32'h0, 32'(oe));
    rchk("supply reset", ADDR_STAT, 32'h2, 32'h2);
    supply <= 1'b0;
    idle(4);
    boot();
    rchk("reset lifted", ADDR_STAT, 32'h2, 32'h0);
    print_verdict();
  end
endmodule : testbench
